// ===== ingress_policing_pkg.sv
// Constants and carrier types for the ingress policing control block.
// Assumes a 20 MHz core clock and a word-indexed register port.
package ingress_policing_pkg;
    // Register indices as seen on the register port
    localparam logic [15:0] BCAST_LIMIT_CTRL_IDX = 16'h1848;
    localparam logic [15:0] VLAN_NONMEMBER_ADMIT_IDX = 16'h1849;
    localparam logic [15:0] INGRESS_METER_CFG_IDX = 16'h184a;
    localparam logic [15:0] METER_TABLE_CMD_IDX = 16'h184b;
    localparam logic [15:0] METER_TABLE_STATUS_IDX = 16'h184c;
    localparam logic [15:0] METER_TABLE_WDATA_IDX = 16'h184d;
    localparam logic [15:0] METER_TABLE_RDATA_IDX = 16'h184e;
    // Broadcast limit field positions
    localparam int BC_EN_BIT_P2 = 26;
    localparam int BC_EN_BIT_P1 = 17;
    localparam int BC_EN_BIT_P0 = 8;
    localparam int BC_LVL_LSB_P2 = 18;
    localparam int BC_LVL_LSB_P1 = 9;
    localparam int BC_LVL_LSB_P0 = 0;
    localparam logic [7:0] BC_LVL_RESET = 8'h02;
    localparam int BC_BYTES_PER_LVL = 64;
    // Broadcast interval: 1.72 ms in ns over a 50 ns clock
    localparam int BC_INTERVAL_NS = 1720000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int BC_INTERVAL_CYC = BC_INTERVAL_NS / CLK_PERIOD_NS;
    // Meter configuration fields
    localparam int CFG_EN_BIT = 0;
    localparam int CFG_MODE_LSB = 1;
    // Command fields
    localparam int CMD_DIR_BIT = 7;
    localparam int CMD_TGT_LSB = 5;
    localparam int CMD_ADDR_LSB = 0;
    localparam int CIR_ENTRIES = 24;
    localparam int CIR_TICK_NS = 20;
    // Table reset values
    localparam logic [15:0] CIR_RESET = 16'h0014;
    localparam logic [15:0] BURST_RESET = 16'h0600;
    // Cycles the table access takes while pending is shown
    localparam int TABLE_ACCESS_CYC = 2;

    // Metering mode
    typedef enum logic [1:0]
    {
        MODE_PORT_PRIO = 2'b00,
        MODE_PORT_ONLY = 2'b01,
        MODE_PRIO_ONLY = 2'b10,
        MODE_RESERVED = 2'b11
    } meter_mode_t;

    // Table target
    typedef enum logic [1:0]
    {
        TGT_RESERVED = 2'b00,
        TGT_CIR = 2'b01,
        TGT_CBS = 2'b10,
        TGT_EBS = 2'b11
    } table_target_t;

    // Register port request
    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [15:0] idx;
        logic [31:0] wdata;
    } reg_req_t;

    // Per-port broadcast input strobe
    typedef struct packed
    {
        logic valid;
        logic [1:0] port;
    } bcast_byte_t;
endpackage : ingress_policing_pkg

// ===== ingress_policing_control.sv
// Ingress admission and policing control: registers, broadcast limiter,
// metering table with indirect command access.
// Assumes a single 20 MHz core clock and a synchronous register port.
`timescale 1ns/100ps
module ingress_policing_control
    import ingress_policing_pkg::*;
#(
    parameter int INTERVAL_CYC = BC_INTERVAL_CYC
)
(
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire reg_req_t reg_req_in,
    input wire bcast_byte_t bcast_byte_in,
    input wire logic [1:0] pkt_port_in,
    input wire logic [4:0] pkt_prio_in,
    output logic [31:0] reg_rdata_out,
    output logic [2:0] bcast_drop_out,
    output logic [2:0] nonmember_admit_out,
    output logic meter_enable_out,
    output logic [15:0] pkt_rate_period_out
);
    localparam int ICW = $clog2(INTERVAL_CYC + 1);
    localparam int BCW = 8 + $clog2(BC_BYTES_PER_LVL) + 1;

    logic [26:0] bc_ctrl_q; // Broadcast limit register
    logic [2:0] admit_q; // Non-member admission bits
    logic [2:0] cfg_q; // Mode and metering enable
    logic [7:0] cmd_q; // Last command
    logic [15:0] wdata_q; // Table write data
    logic [15:0] rdata_q; // Table read result
    logic pending_q; // Operation pending
    logic [1:0] busy_cnt_q; // Access progress
    logic [15:0] cir_q [CIR_ENTRIES]; // Committed rate entries
    logic [15:0] cbs_q; // Committed burst
    logic [15:0] ebs_q; // Excess burst
    logic [ICW-1:0] ivl_cnt_q; // Interval timer
    logic [BCW-1:0] bc_cnt_q [3]; // Bytes seen per port
    logic [BCW-1:0] bc_nxt [3]; // Byte count after this cycle
    logic cmd_wr; // Command write strobe
    logic [2:0] bc_en; // Enable per port
    logic [7:0] bc_lvl [3]; // Level per port
    logic ivl_end; // Interval boundary
    logic [4:0] rate_idx; // Metering entry index

    assign cmd_wr = reg_req_in.wr && reg_req_in.idx == METER_TABLE_CMD_IDX;
    assign bc_en = {bc_ctrl_q[BC_EN_BIT_P2], bc_ctrl_q[BC_EN_BIT_P1],
                    bc_ctrl_q[BC_EN_BIT_P0]};
    assign bc_lvl[0] = bc_ctrl_q[BC_LVL_LSB_P0 +: 8];
    assign bc_lvl[1] = bc_ctrl_q[BC_LVL_LSB_P1 +: 8];
    assign bc_lvl[2] = bc_ctrl_q[BC_LVL_LSB_P2 +: 8];
    assign ivl_end = ivl_cnt_q == ICW'(INTERVAL_CYC - 1);

    // Configuration register writes
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            bc_ctrl_q <= {1'b0, BC_LVL_RESET, 1'b0, BC_LVL_RESET, 1'b0,
                          BC_LVL_RESET};
            admit_q <= 3'h0;
            cfg_q <= 3'h0;
            wdata_q <= 16'h0000;
        end
        else if (reg_req_in.wr)
        begin
            case (reg_req_in.idx)
                BCAST_LIMIT_CTRL_IDX: bc_ctrl_q <= reg_req_in.wdata[26:0];
                VLAN_NONMEMBER_ADMIT_IDX: admit_q <= reg_req_in.wdata[2:0];
                INGRESS_METER_CFG_IDX: cfg_q <= reg_req_in.wdata[2:0];
                METER_TABLE_WDATA_IDX: wdata_q <= reg_req_in.wdata[15:0];
                default: ;
            endcase
        end
    end

    // Command capture and pending flag; a write while busy is ignored
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cmd_q <= 8'h00;
            pending_q <= 1'b0;
            busy_cnt_q <= 2'h0;
        end
        else if (cmd_wr && !pending_q)
        begin
            cmd_q <= reg_req_in.wdata[7:0];
            pending_q <= 1'b1;
            busy_cnt_q <= 2'(TABLE_ACCESS_CYC - 1);
        end
        else if (pending_q)
        begin
            if (busy_cnt_q == 2'h0)
                pending_q <= 1'b0;
            else
                busy_cnt_q <= busy_cnt_q - 2'h1;
        end
    end

    // Table access performed on the last pending cycle
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            for (int i = 0; i < CIR_ENTRIES; i++)
                cir_q[i] <= CIR_RESET;
            cbs_q <= BURST_RESET;
            ebs_q <= BURST_RESET;
            rdata_q <= 16'h0000;
        end
        else if (pending_q && busy_cnt_q == 2'h0)
        begin
            if (cmd_q[CMD_DIR_BIT]) // read
            begin
                case (table_target_t'(cmd_q[CMD_TGT_LSB +: 2]))
                    TGT_CIR: rdata_q <= (cmd_q[4:0] < 5'(CIR_ENTRIES)) ?
                        cir_q[cmd_q[4:0]] : 16'h0000;
                    TGT_CBS: rdata_q <= cbs_q;
                    TGT_EBS: rdata_q <= ebs_q;
                    default: rdata_q <= 16'h0000;
                endcase
            end
            else
            begin
                case (table_target_t'(cmd_q[CMD_TGT_LSB +: 2]))
                    TGT_CIR:
                        if (cmd_q[4:0] < 5'(CIR_ENTRIES))
                            cir_q[cmd_q[4:0]] <= wdata_q;
                    TGT_CBS: cbs_q <= wdata_q;
                    TGT_EBS: ebs_q <= wdata_q;
                    default: ;
                endcase
            end
        end
    end

    // Register read data
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            reg_rdata_out <= 32'h0000_0000;
        else if (reg_req_in.rd)
        begin
            case (reg_req_in.idx)
                BCAST_LIMIT_CTRL_IDX: reg_rdata_out <= {5'h00, bc_ctrl_q};
                VLAN_NONMEMBER_ADMIT_IDX: reg_rdata_out <= {29'h0, admit_q};
                INGRESS_METER_CFG_IDX: reg_rdata_out <= {29'h0, cfg_q};
                METER_TABLE_CMD_IDX: reg_rdata_out <= {24'h0, cmd_q};
                METER_TABLE_STATUS_IDX: reg_rdata_out <= {31'h0, pending_q};
                METER_TABLE_WDATA_IDX: reg_rdata_out <= {16'h0, wdata_q};
                METER_TABLE_RDATA_IDX: reg_rdata_out <= {16'h0, rdata_q};
                default: reg_rdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // Interval timer for broadcast allowance
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            ivl_cnt_q <= '0;
        else if (ivl_end)
            ivl_cnt_q <= '0;
        else
            ivl_cnt_q <= ivl_cnt_q + ICW'(1);
    end

    // Count including the byte arriving in this cycle, so the flag rises
    // right after the last allowed byte and not one byte later
    always_comb
    begin
        for (int p = 0; p < 3; p++)
        begin
            bc_nxt[p] = bc_cnt_q[p];
            if (bcast_byte_in.valid && bcast_byte_in.port == 2'(p)
                && bc_cnt_q[p] != '1)
                bc_nxt[p] = bc_cnt_q[p] + BCW'(1);
        end
    end

    // Broadcast byte counting and drop decision per port
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            for (int p = 0; p < 3; p++)
                bc_cnt_q[p] <= '0;
            bcast_drop_out <= 3'h0;
        end
        else
        begin
            for (int p = 0; p < 3; p++)
            begin
                if (ivl_end)
                    bc_cnt_q[p] <= '0;
                else
                    bc_cnt_q[p] <= bc_nxt[p];
                // Drop once the byte count reaches level x 64
                bcast_drop_out[p] <= bc_en[p] && !ivl_end &&
                    bc_nxt[p] >= BCW'({bc_lvl[p], 6'h00});
            end
        end
    end

    // Entry index per metering mode
    always_comb
    begin
        case (meter_mode_t'(cfg_q[CFG_MODE_LSB +: 2]))
            MODE_PORT_PRIO:
                rate_idx = 5'({pkt_port_in, pkt_prio_in[2:0]});
            MODE_PORT_ONLY: rate_idx = {3'h0, pkt_port_in};
            MODE_PRIO_ONLY: rate_idx = pkt_prio_in;
            default: rate_idx = 5'h00;
        endcase
    end

    // Admission, enable and rate outputs
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            nonmember_admit_out <= 3'h0;
            meter_enable_out <= 1'b0;
            pkt_rate_period_out <= 16'h0000;
        end
        else
        begin
            nonmember_admit_out <= admit_q;
            meter_enable_out <= cfg_q[CFG_EN_BIT];
            // Period in 20 ns ticks less one
            pkt_rate_period_out <= (rate_idx < 5'(CIR_ENTRIES)) ?
                cir_q[rate_idx] : 16'h0000;
        end
    end

    // Pending lasts exactly the access length
    property p_pending_len;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (cmd_wr && !pending_q) |=> pending_q [*2] ##1 !pending_q;
    endproperty
    a_pending_len: assert property (p_pending_len)
        else $error("pending length wrong");

    // Command write launches access
    property p_cmd_launch;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (cmd_wr && !pending_q) |=> pending_q && cmd_q ==
            $past(reg_req_in.wdata[7:0]);
    endproperty
    a_cmd_launch: assert property (p_cmd_launch)
        else $error("command not launched");

    // Write of excess burst entry lands in ebs_q
    sequence s_done;
        pending_q ##1 !pending_q;
    endsequence
    property p_wr_ebs;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (cmd_wr && !pending_q && reg_req_in.wdata[7:5] == 3'b011)
            |=> ##1 s_done ##0 ebs_q == $past(wdata_q);
    endproperty
    a_wr_ebs: assert property (p_wr_ebs)
        else $error("excess burst write lost");

    // Drop never asserted while limiting disabled
    property p_no_drop_disabled;
        @(posedge core_clk_in) disable iff (!nrst_in)
        !$past(bc_en[0]) |-> !bcast_drop_out[0];
    endproperty
    a_no_drop_disabled: assert property (p_no_drop_disabled)
        else $error("drop while disabled");

    // Counters restart after interval boundary
    property p_restart;
        @(posedge core_clk_in) disable iff (!nrst_in)
        ivl_end |=> bc_cnt_q[0] == '0 && bcast_drop_out == 3'h0;
    endproperty
    a_restart: assert property (p_restart)
        else $error("allowance not restarted");

    // Drop follows a full allowance
    property p_drop_level;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (bc_en[0] && !ivl_end && bc_cnt_q[0] >= BCW'({bc_lvl[0], 6'h00}))
            |=> bcast_drop_out[0];
    endproperty
    a_drop_level: assert property (p_drop_level)
        else $error("allowance overrun not dropped");

    // Enable output follows configuration bit
    property p_meter_en;
        @(posedge core_clk_in) disable iff (!nrst_in)
        $rose(cfg_q[CFG_EN_BIT]) |=> meter_enable_out;
    endproperty
    a_meter_en: assert property (p_meter_en)
        else $error("meter enable not followed");

    // Admission output follows register
    property p_admit;
        @(posedge core_clk_in) disable iff (!nrst_in)
        1'b1 |=> nonmember_admit_out == $past(admit_q);
    endproperty
    a_admit: assert property (p_admit)
        else $error("admission bits wrong");
endmodule : ingress_policing_control

// ===== testbench.sv
// Self-checking bench for the ingress policing control block.
// Assumes the block's package and a 20 MHz clock; inputs move on falling edges.
`timescale 1ns/100ps
module testbench;
    import ingress_policing_pkg::*;
    // Short broadcast interval keeps the run brief
    localparam int IV = 200;
    logic core_clk_in;
    logic nrst_in;
    reg_req_t reg_req_in;
    bcast_byte_t bcast_byte_in;
    logic [1:0] pkt_port_in;
    logic [4:0] pkt_prio_in;
    logic [31:0] reg_rdata_out;
    logic [2:0] bcast_drop_out;
    logic [2:0] nonmember_admit_out;
    logic meter_enable_out;
    logic [15:0] pkt_rate_period_out;
    int fail_count;
    int compares;

    // Device under test
    ingress_policing_control #(.INTERVAL_CYC(IV)) ingress_policing_control_i
    (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .reg_req_in(reg_req_in),
        .bcast_byte_in(bcast_byte_in),
        .pkt_port_in(pkt_port_in),
        .pkt_prio_in(pkt_prio_in),
        .reg_rdata_out(reg_rdata_out),
        .bcast_drop_out(bcast_drop_out),
        .nonmember_admit_out(nonmember_admit_out),
        .meter_enable_out(meter_enable_out),
        .pkt_rate_period_out(pkt_rate_period_out)
    );

    // Clock at 50 ns period
    initial
    begin
        core_clk_in = 1'b0;
        forever #25 core_clk_in = ~core_clk_in;
    end

    // Prints the counts and the verdict, then ends the run
    task automatic test_done();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    // Compares one value with its expectation
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One register cycle; read data has landed when this returns
    task automatic reg_op(input logic wr, input logic [15:0] idx,
                          input logic [31:0] d);
        reg_req_in.wr = wr;
        reg_req_in.rd = ~wr;
        reg_req_in.idx = idx;
        reg_req_in.wdata = d;
        @(negedge core_clk_in);
        reg_req_in.wr = 1'b0;
        reg_req_in.rd = 1'b0;
        @(negedge core_clk_in);
    endtask : reg_op

    // Reads a register and compares it
    task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp,
                          input string what);
        reg_op(1'b0, idx, 32'h0);
        check(what, reg_rdata_out, exp);
    endtask : rd_chk

    // Issues a table command and polls the pending flag until it clears
    task automatic table_op(input logic [31:0] cmd);
        int n;
        n = 0;
        reg_op(1'b1, METER_TABLE_CMD_IDX, cmd);
        do
        begin
            reg_op(1'b0, METER_TABLE_STATUS_IDX, 32'h0);
            n++;
        end
        while (reg_rdata_out[0] !== 1'b0 && n < 20);
        check("pending cleared", reg_rdata_out, 32'h0);
    endtask : table_op

    // Register reset values and an unmapped index
    task automatic t_reset();
        rd_chk(BCAST_LIMIT_CTRL_IDX, 32'h0008_0402, "bcast reset");
        rd_chk(VLAN_NONMEMBER_ADMIT_IDX, 32'h0, "admit reset");
        rd_chk(INGRESS_METER_CFG_IDX, 32'h0, "cfg reset");
        rd_chk(METER_TABLE_WDATA_IDX, 32'h0, "wdata reset");
        rd_chk(16'h1850, 32'h0, "unmapped read");
    endtask : t_reset

    // Field widths, reserved bits and the copies on the outputs
    task automatic t_regs();
        reg_op(1'b1, BCAST_LIMIT_CTRL_IDX, 32'hffff_ffff);
        rd_chk(BCAST_LIMIT_CTRL_IDX, 32'h07ff_ffff, "bcast fields");
        reg_op(1'b1, VLAN_NONMEMBER_ADMIT_IDX, 32'hffff_fffe);
        rd_chk(VLAN_NONMEMBER_ADMIT_IDX, 32'h6, "admit bits");
        check("admit out", 32'(nonmember_admit_out), 32'h6);
        reg_op(1'b1, INGRESS_METER_CFG_IDX, 32'hffff_fffd);
        rd_chk(INGRESS_METER_CFG_IDX, 32'h5, "cfg fields");
        check("meter enable", 32'(meter_enable_out), 32'h1);
    endtask : t_regs

    // Indirect table access: defaults, writes, reserved and range limits
    task automatic t_table();
        table_op(32'h0000_00a0);
        rd_chk(METER_TABLE_RDATA_IDX, 32'h0014, "rate default");
        table_op(32'h0000_00c0);
        rd_chk(METER_TABLE_RDATA_IDX, 32'h0600, "cbs default");
        table_op(32'h0000_00e0);
        rd_chk(METER_TABLE_RDATA_IDX, 32'h0600, "ebs default");
        reg_op(1'b1, METER_TABLE_WDATA_IDX, 32'habcd_1234);
        rd_chk(METER_TABLE_WDATA_IDX, 32'h1234, "wdata width");
        table_op(32'h0000_0029);
        table_op(32'h0000_00a9);
        rd_chk(METER_TABLE_RDATA_IDX, 32'h1234, "rate 9");
        table_op(32'h0000_0040);
        table_op(32'h0000_00c0);
        rd_chk(METER_TABLE_RDATA_IDX, 32'h1234, "cbs write");
        table_op(32'h0000_0060);
        table_op(32'h0000_00e0);
        rd_chk(METER_TABLE_RDATA_IDX, 32'h1234, "ebs write");
        table_op(32'h0000_0080);
        rd_chk(METER_TABLE_RDATA_IDX, 32'h0, "reserved target");
        table_op(32'h0000_00b8);
        rd_chk(METER_TABLE_RDATA_IDX, 32'h0, "index 24");
        reg_op(1'b1, METER_TABLE_WDATA_IDX, 32'h0000_5555);
        table_op(32'h0000_0021);
    endtask : t_table

    // Sets a mode and packet source, then checks the looked-up entry
    task automatic m_case(input logic [1:0] mode, input logic [1:0] port,
                          input logic [4:0] prio, input logic [15:0] exp);
        reg_op(1'b1, INGRESS_METER_CFG_IDX, {29'h0, mode, 1'b1});
        pkt_port_in = port;
        pkt_prio_in = prio;
        repeat (3) @(negedge core_clk_in);
        check("rate lookup", 32'(pkt_rate_period_out), 32'(exp));
    endtask : m_case

    // Broadcast limit on port 0, none on port 1
    task automatic t_bcast();
        int n;
        reg_op(1'b1, BCAST_LIMIT_CTRL_IDX, 32'h0000_0301);
        bcast_byte_in = '{valid: 1'b1, port: 2'd0};
        for (n = 0; n < 2 * IV && bcast_drop_out[0] !== 1'b1; n++)
            @(negedge core_clk_in);
        check("drop rises", 32'(bcast_drop_out[0]), 32'h1);
        for (n = 0; n < IV + 4 && bcast_drop_out[0] !== 1'b0; n++)
            @(negedge core_clk_in);
        check("drop restarts", 32'(bcast_drop_out[0]), 32'h0);
        // A fresh interval has just begun: count the bytes let through
        for (n = 0; n < 2 * IV && bcast_drop_out[0] !== 1'b1; n++)
            @(negedge core_clk_in);
        check("bytes before drop", 32'(n), 32'(BC_BYTES_PER_LVL));
        bcast_byte_in.port = 2'd1;
        for (n = 0; n < 150 && bcast_drop_out[1] !== 1'b1; n++)
            @(negedge core_clk_in);
        check("port 1 unlimited", 32'(bcast_drop_out[1]), 32'h0);
        bcast_byte_in.valid = 1'b0;
    endtask : t_bcast

    // Cuts a hang short
    initial
    begin
        repeat (20000) @(posedge core_clk_in);
        fail_count++;
        test_done();
    end

    // Main sequence
    initial
    begin
        fail_count = 0;
        compares = 0;
        nrst_in = 1'b0;
        reg_req_in = '0;
        bcast_byte_in = '0;
        pkt_port_in = 2'd0;
        pkt_prio_in = 5'd0;
        repeat (8) @(posedge core_clk_in);
        @(negedge core_clk_in);
        nrst_in = 1'b1;
        @(negedge core_clk_in);
        t_reset();
        t_regs();
        t_table();
        m_case(2'b00, 2'd1, 5'd1, 16'h1234);
        m_case(2'b00, 2'd2, 5'd0, 16'h0014);
        m_case(2'b01, 2'd1, 5'd0, 16'h5555);
        m_case(2'b10, 2'd0, 5'd9, 16'h1234);
        m_case(2'b10, 2'd2, 5'd24, 16'h0000);
        t_bcast();
        test_done();
    end
endmodule : testbench
